// ---- rtl/tsc_counter_control.sv ----
// Touch sense counter: register slave, counters, event select and status flags
module tsc_counter_control
  import tsc_pkg::*;
(
  input  logic        hclk,
  input  logic        hresetn,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  input  logic        comparator0,
  input  logic        comparator1,
  input  logic        slow_internal_osc,
  input  logic        internal_timer,
  input  logic        analog_bus,
  input  logic        relax_osc,
  output logic        unit_irq,
  output logic        timer_terminal_count,
  output logic        pin_precharge_clk,
  output logic        pin_precharge_clock_enable,
  output logic        relax_osc_enable,
  output logic        charge_integration_enable,
  output logic [1:0]  current_scale,
  output logic        current_direction,
  output logic        current_bus_connect,
  output logic        current_offset_add,
  output logic        reference_source_select,
  output logic        reference_buffer_enable,
  output logic        reference_connect,
  output logic [1:0]  lowpass_time_constant,
  output logic [1:0]  lowpass_insert_select
);

  //----------------------------------------
  // State
  //----------------------------------------
  typedef struct packed {
    logic [7:0]  run;
    logic [7:0]  cfg;
    logic [7:0]  ana;
    logic [7:0]  filt;
    logic [5:0]  reload;
    logic [7:0]  low;
    logic [7:0]  high;
    logic [3:0]  flags;
    logic [3:0]  masks;
    tsc_state_t  st;
    logic [2:0]  div;
    logic        pin_clk;
    logic        ev_prev;
    logic        osc_prev;
    logic        irq;
    logic        ref_conn;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  idx;
    logic [31:0] rdata;
  } tsc_regs_t;

  tsc_regs_t q;
  tsc_regs_t next_q;

  //----------------------------------------
  // Decoded controls
  //----------------------------------------
  logic        en;
  tsc_mode_t   mode;
  tsc_src_t    src;
  logic [1:0]  csel;
  logic        chain;
  logic        osc_sel;
  logic        flip;
  logic        pxd;
  logic        div_tick;
  logic        osc_tick;
  logic        ev_raw;
  logic        ev;
  logic        ev_rise;
  logic        ev_fall;
  logic        counting;
  logic        running;
  logic        low_inc;
  logic        low_carry;
  logic        high_inc;
  logic        high_carry;
  logic        done_ev;
  logic [3:0]  ev_set;
  logic        stop;
  logic        acc;
  logic        stat_wr;
  logic [3:0]  flag_keep;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  tsc_timer_if tif ();

  // Field views of the control registers
  assign en      = q.run[TSC_EN_BIT];
  assign mode    = tsc_mode_t'(q.run[TSC_MODE_LO +: 2]);
  assign src     = tsc_src_t'(q.cfg[TSC_SRC_LO +: 3]);
  assign csel    = q.cfg[TSC_CLKDIV_LO +: 2];
  assign chain   = q.cfg[TSC_CHAIN_BIT];
  assign osc_sel = q.cfg[TSC_OSCSEL_BIT];
  assign flip    = q.cfg[TSC_FLIP_BIT];
  assign pxd     = q.ana[TSC_PXD_BIT];
  assign wbyte   = hwdata[7:0];

  //----------------------------------------
  // Clock division and event input
  //----------------------------------------
  // One-cycle tick at the selected rate; a tick is used instead of a
  // derived clock so the whole unit stays in one domain
  always_comb begin
    unique case (csel)
      2'b00: div_tick = 1'b1;
      2'b01: div_tick = q.div[0];
      2'b10: div_tick = &q.div[1:0];
      2'b11: div_tick = &q.div;
    endcase
  end

  // Relax oscillator arrives as a synchronous level; its rise is a tick
  assign osc_tick = relax_osc & ~q.osc_prev;

  // Event source multiplexer
  always_comb begin
    unique case (src)
      TSC_SRC_CMP0: ev_raw = comparator0;
      TSC_SRC_SLOW: ev_raw = slow_internal_osc;
      TSC_SRC_CMP1: ev_raw = comparator1;
      TSC_SRC_TC:   ev_raw = tif.tc;
      TSC_SRC_ITMR: ev_raw = internal_timer;
      TSC_SRC_TIRQ: ev_raw = tif.fired;
      TSC_SRC_ABUS: ev_raw = analog_bus;
      TSC_SRC_ZERO: ev_raw = 1'b0;
    endcase
  end

  // Polarity and edges of the chosen event
  assign ev      = ev_raw ^ flip;
  assign ev_rise = ev & ~q.ev_prev;
  assign ev_fall = ~ev & q.ev_prev;

  //----------------------------------------
  // Counters and events
  //----------------------------------------
  assign counting   = en && (q.st == TSC_ST_COUNT);
  assign running    = en && (q.st == TSC_ST_ARM || q.st == TSC_ST_COUNT);
  assign low_inc    = counting & div_tick;
  assign low_carry  = low_inc & (&q.low);
  // Cascade takes the low carry; otherwise the high counter has its own clock
  assign high_inc   = counting & (chain ? low_carry : (osc_sel ? osc_tick : div_tick));
  assign high_carry = high_inc & (&q.high);

  // Measurement end: width ends on the fall, period on the next rise
  assign done_ev = counting && ((mode == TSC_MODE_WIDTH && ev_fall) ||
                                (mode == TSC_MODE_PERIOD && ev_rise));

  // Events post only while running
  assign ev_set = running ? {ev_rise, low_carry, high_carry, done_ev} : 4'h0;

  // Stop on any enabled event in mode 00, on the end of a measurement in modes 01 and 10; mode 11 never stops
  assign stop = counting && (done_ev || (mode == TSC_MODE_STOP && |(ev_set & q.masks)));

  //----------------------------------------
  // Bus decode
  //----------------------------------------
  assign acc       = hsel && hready && htrans[1];
  assign stat_wr   = q.wr_pend && (q.idx == TSC_IDX_STAT);
  assign flag_keep = stat_wr ? wbyte[TSC_FLAG_LO +: 4] : 4'hf;

  // Read multiplexer; unmapped words read zero
  always_comb begin
    case (q.idx)
      TSC_IDX_RUN:  rd_byte = q.run;
      TSC_IDX_CFG:  rd_byte = q.cfg;
      TSC_IDX_ANA:  rd_byte = q.ana;
      TSC_IDX_FILT: rd_byte = q.filt;
      TSC_IDX_LOW:  rd_byte = q.low;
      TSC_IDX_HIGH: rd_byte = q.high;
      TSC_IDX_STAT: rd_byte = {q.flags, q.masks};
      TSC_IDX_TMR:  rd_byte = {2'b00, q.reload};
      default:      rd_byte = 8'h00;
    endcase
  end

  //----------------------------------------
  // Next state
  //----------------------------------------
  always_comb begin
    next_q          = q;
    next_q.div      = q.div + 3'h1;
    next_q.osc_prev = relax_osc;
    next_q.ev_prev  = ev;
    // Pin clock toggles per tick, so it runs at half the tick rate
    next_q.pin_clk  = pxd ? (q.pin_clk ^ div_tick) : 1'b0;

    // Address phase; a read holds one wait state so it sees any prior write
    next_q.wr_pend = 1'b0;
    next_q.rd_pend = 1'b0;
    if (acc) begin
      next_q.idx     = (haddr[31:10] == '0 && haddr[1:0] == 2'b00) ? haddr[9:2] : TSC_IDX_NONE;
      next_q.wr_pend = hwrite && (hsize == TSC_HSIZE_WORD);
      next_q.rd_pend = !hwrite;
    end
    if (q.rd_pend) begin
      next_q.rdata = {24'h00_0000, rd_byte};
    end

    // Data phase of a write; configuration is taken as written, except unused run, analog and timer bits, which are masked to zero
    if (q.wr_pend) begin
      case (q.idx)
        TSC_IDX_RUN:  next_q.run    = wbyte & TSC_RUN_MASK;
        TSC_IDX_CFG:  next_q.cfg    = wbyte;
        TSC_IDX_ANA:  next_q.ana    = wbyte & TSC_ANA_MASK;
        TSC_IDX_FILT: next_q.filt   = wbyte;
        TSC_IDX_STAT: next_q.masks  = wbyte[3:0];
        TSC_IDX_TMR:  next_q.reload = wbyte[5:0];
        default:      next_q.run    = q.run; // Count registers ignore writes
      endcase
    end

    // Counters
    if (low_inc) begin
      next_q.low = q.low + 8'h01;
    end
    if (high_inc) begin
      next_q.high = q.high + 8'h01;
    end

    // Flags: a new event wins over a clear in the same cycle
    next_q.flags = (q.flags & flag_keep) | ev_set;

    // Run sequence
    unique case (q.st)
      TSC_ST_OFF: begin
        if (en) begin
          next_q.st = (mode == TSC_MODE_WIDTH || mode == TSC_MODE_PERIOD) ?
                      TSC_ST_ARM : TSC_ST_COUNT;
        end
      end
      TSC_ST_ARM: begin
        if (ev_rise) begin
          next_q.st = TSC_ST_COUNT;
        end
      end
      TSC_ST_COUNT: begin
        if (stop) begin
          next_q.st = TSC_ST_HOLD; // Count is held for reading
        end
      end
      TSC_ST_HOLD: begin
        next_q.st = TSC_ST_HOLD;
      end
    endcase

    // Disable wipes counters and flags, whatever else happened
    if (!en) begin
      next_q.st    = TSC_ST_OFF;
      next_q.low   = 8'h00;
      next_q.high  = 8'h00;
      next_q.flags = 4'h0;
    end

    next_q.irq      = |(next_q.flags & next_q.masks);
    next_q.ref_conn = next_q.filt[TSC_REFMAN_BIT] &
                      ~(next_q.ana[TSC_CI_BIT] | next_q.ana[TSC_RO_BIT]);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  //----------------------------------------
  // Timer
  //----------------------------------------
  // Timer follows the divided clock tick when precharge is on, else relax_osc
  assign tif.tick   = pxd ? div_tick : osc_tick;
  assign tif.start  = en;
  assign tif.reload = q.reload;

  tsc_one_shot u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  //----------------------------------------
  // Outputs
  //----------------------------------------
  assign hreadyout            = ~q.rd_pend;
  assign hresp                = 1'b0;
  assign hrdata               = q.rdata;
  assign unit_irq             = q.irq;
  assign timer_terminal_count = tif.tc;
  assign pin_precharge_clk    = q.pin_clk;

  // Static analog controls
  assign pin_precharge_clock_enable = pxd;
  assign relax_osc_enable           = q.ana[TSC_RO_BIT];
  assign charge_integration_enable  = q.ana[TSC_CI_BIT];
  assign current_scale              = q.ana[TSC_SCALE_LO +: 2];
  assign current_direction          = q.ana[TSC_DIR_BIT];
  assign current_bus_connect        = q.ana[TSC_BUSC_BIT];
  assign current_offset_add         = q.filt[TSC_OFFS_BIT];
  assign reference_source_select    = q.filt[TSC_REFSEL_BIT];
  assign reference_buffer_enable    = q.filt[TSC_REFEN_BIT];
  assign reference_connect          = q.ref_conn;
  assign lowpass_time_constant      = q.filt[TSC_LPT_LO +: 2];
  assign lowpass_insert_select      = q.filt[TSC_LPI_LO +: 2];

  //----------------------------------------
  // Checks
  //----------------------------------------
  default clocking tsc_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_chain_carry: assert property (chain && low_carry |=> q.high == 8'($past(q.high) + 8'h01))
    else $error("cascade carry did not advance high counter");
  a_split_hold: assert property (counting && !chain && osc_sel && !osc_tick |=> q.high == $past(q.high))
    else $error("high counter moved without oscillator tick");
  a_div_eighth: assert property (csel == 2'b11 && div_tick |-> q.div == 3'h7)
    else $error("divide by eight tick misplaced");
  a_div_full: assert property (csel == 2'b00 |-> div_tick)
    else $error("undivided clock missed a tick");
  a_zero_src: assert property (src == TSC_SRC_ZERO |-> ev_raw == 1'b0)
    else $error("source 111 not zero");
  a_flip_edge: assert property (running && flip && $fell(ev_raw) && $stable(q.cfg) |=> q.flags[TSC_EV_EDGE])
    else $error("inverted falling input did not flag an edge");
  a_edge_flag: assert property (running && ev_rise |=> q.flags[TSC_EV_EDGE])
    else $error("rising edge not flagged");
  a_set_wins: assert property (running && low_carry && stat_wr && !wbyte[6] |=> q.flags[TSC_EV_LOWC])
    else $error("carry lost against a clear");
  a_write_clear: assert property (en && stat_wr && !wbyte[4] && !done_ev |=> !q.flags[TSC_EV_DONE])
    else $error("writing zero did not clear the flag");
  a_off_clear: assert property (!en |=> q.flags == 4'h0 && q.low == 8'h00 && q.high == 8'h00)
    else $error("disable left counts or flags");
  a_period_done: assert property (counting && mode == TSC_MODE_PERIOD && ev_rise
                                  |=> q.st == TSC_ST_HOLD && q.flags[TSC_EV_DONE])
    else $error("period end not detected");
  a_arm_start: assert property (en && q.st == TSC_ST_ARM && ev_rise ##1 en |-> q.st == TSC_ST_COUNT)
    else $error("measurement did not start on rise");
  a_irq_mask: assert property ((q.flags & q.masks) == 4'h0 |-> !unit_irq)
    else $error("masked event raised interrupt");
  a_irq_pend: assert property (running && ev_rise && q.masks[TSC_EV_EDGE] |=> unit_irq)
    else $error("pending event did not raise interrupt");
  a_ref_gate: assert property (q.ana[TSC_CI_BIT] || q.ana[TSC_RO_BIT] |-> !reference_connect)
    else $error("reference connect not gated");
  a_cnt_ro: assert property (q.wr_pend && q.idx == TSC_IDX_LOW && !low_inc && en |=> q.low == $past(q.low))
    else $error("write altered the low count");
  a_pin_clk: assert property (!pxd |=> !pin_precharge_clk)
    else $error("pin clock ran while disabled");
  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_chain_high: cover property (chain && high_carry);
  c_width_done: cover property (mode == TSC_MODE_WIDTH && done_ev);
  c_stop_event: cover property (mode == TSC_MODE_STOP && stop);
  c_irq_rise: cover property (!unit_irq ##1 unit_irq);

endmodule : tsc_counter_control

// ---- pkg/tsc_pkg.sv ----
// Package: register indices, field positions and codes of the touch sense counter
//------------------------------------------------------------------------------
// Behaviour
// - Cascade clear: two independent 8-bit counters; set: one 16-bit counter.
// - Clock divide select 00..11 runs the unit at main_osc divided by 1,2,4,8.
// - Oscillator clock bit set clocks only the high counter from relax_osc; with cascade set the code ignores it and the low carry clocks the high counter.
// - Polarity flip set inverts the selected event input, clear passes it.
// - Source codes 000..110 pick event inputs; code 111 gives constant zero.
// - Precharge enable drives the divided clock to bus pins and the timer.
// - Manual reference connect is ignored when integration or relaxation is enabled.
// - Low count register reads the low counter; writes do not alter it.
// - High count register reads the high counter; writes do not alter it.
// - Upper four status bits are the pending interrupts; clearing one clears it.
// - Flags set only while enabled and running; disabling clears them all.
// - A rising edge on the event input sets the input edge flag.
// - Low and high counter overflows set the low and high carry flags.
// - Completion of a pulse width or period measurement sets the done flag.
// - Writing zero clears a status flag; writing one leaves it.
// - Interrupt asserts for any pending event whose mask bit is one.
// - Timer register holds a 6-bit start count; upper two bits reserved.
// - Enable starts the timer once: load, count to zero, one-cycle pulse, stop.
// - Disable stops counting and zeroes counters; enable starts a new count.
// - Modes: stop on event, pulse width, period, continuous; measurements start on rise.
//------------------------------------------------------------------------------
package tsc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] TSC_IDX_RUN    = 8'ha0;
  localparam logic [7:0] TSC_IDX_CFG    = 8'ha1;
  localparam logic [7:0] TSC_IDX_ANA    = 8'ha2;
  localparam logic [7:0] TSC_IDX_FILT   = 8'ha3;
  localparam logic [7:0] TSC_IDX_LOW    = 8'ha4;
  localparam logic [7:0] TSC_IDX_HIGH   = 8'ha5;
  localparam logic [7:0] TSC_IDX_STAT   = 8'ha6;
  localparam logic [7:0] TSC_IDX_TMR    = 8'ha7;
  localparam logic [7:0] TSC_IDX_NONE   = 8'hff;
  localparam logic [7:0] TSC_RUN_MASK   = 8'h07;
  localparam logic [7:0] TSC_ANA_MASK   = 8'hf7;
  localparam logic [2:0] TSC_HSIZE_WORD = 3'h2;

  // run_control fields
  localparam int TSC_EN_BIT     = 0;
  localparam int TSC_MODE_LO    = 1;
  // counter_config fields
  localparam int TSC_CHAIN_BIT  = 7;
  localparam int TSC_CLKDIV_LO  = 5;
  localparam int TSC_OSCSEL_BIT = 4;
  localparam int TSC_FLIP_BIT   = 3;
  localparam int TSC_SRC_LO     = 0;
  // sense_analog_control fields
  localparam int TSC_SCALE_LO   = 6;
  localparam int TSC_DIR_BIT    = 5;
  localparam int TSC_BUSC_BIT   = 4;
  localparam int TSC_PXD_BIT    = 2;
  localparam int TSC_CI_BIT     = 1;
  localparam int TSC_RO_BIT     = 0;
  // filter_reference_control fields
  localparam int TSC_OFFS_BIT   = 7;
  localparam int TSC_REFSEL_BIT = 6;
  localparam int TSC_REFMAN_BIT = 5;
  localparam int TSC_REFEN_BIT  = 4;
  localparam int TSC_LPT_LO     = 2;
  localparam int TSC_LPI_LO     = 0;
  // event_flags_masks: flags in the upper nibble, event order inside a nibble
  localparam int TSC_FLAG_LO    = 4;
  localparam int TSC_EV_EDGE    = 3;
  localparam int TSC_EV_LOWC    = 2;
  localparam int TSC_EV_HIGHC   = 1;
  localparam int TSC_EV_DONE    = 0;
  localparam int TSC_RELOAD_W   = 6;

  typedef enum logic [1:0] {
    TSC_MODE_STOP   = 2'b00,
    TSC_MODE_WIDTH  = 2'b01,
    TSC_MODE_PERIOD = 2'b10,
    TSC_MODE_CONT   = 2'b11
  } tsc_mode_t;

  typedef enum logic [1:0] {
    TSC_ST_OFF   = 2'b00,
    TSC_ST_ARM   = 2'b01,
    TSC_ST_COUNT = 2'b10,
    TSC_ST_HOLD  = 2'b11
  } tsc_state_t;

  typedef enum logic [2:0] {
    TSC_SRC_CMP0 = 3'b000,
    TSC_SRC_SLOW = 3'b001,
    TSC_SRC_CMP1 = 3'b010,
    TSC_SRC_TC   = 3'b011,
    TSC_SRC_ITMR = 3'b100,
    TSC_SRC_TIRQ = 3'b101,
    TSC_SRC_ABUS = 3'b110,
    TSC_SRC_ZERO = 3'b111
  } tsc_src_t;

endpackage : tsc_pkg

// ---- pkg/tsc_timer_if.sv ----
// Interface between the counter control and its one-shot timer
interface tsc_timer_if;
  logic       tick;
  logic       start;
  logic [5:0] reload;
  logic       tc;
  logic       fired;
  modport ctrl  (output tick, start, reload, input tc, fired);
  modport timer (input tick, start, reload, output tc, fired);
endinterface : tsc_timer_if

// ---- rtl/tsc_one_shot.sv ----
// Six-bit one-shot down timer with a terminal count pulse
module tsc_one_shot
  import tsc_pkg::*;
(
  input logic        hclk,
  input logic        hresetn,
  tsc_timer_if.timer tif
);

  //----------------------------------------
  // State
  //----------------------------------------
  typedef struct packed {
    logic [TSC_RELOAD_W-1:0] cnt;
    logic                    started;
    logic                    running;
    logic                    fired;
    logic                    tc;
  } tsc_tmr_t;

  tsc_tmr_t q;
  tsc_tmr_t next_q;

  // Load once per enable, count ticks down, pulse at zero, then stay idle
  always_comb begin
    next_q = q;
    next_q.tc = 1'b0;
    if (!tif.start) begin
      next_q = '0; // Only a fresh enable restarts the count
    end else if (!q.started) begin
      next_q.started = 1'b1;
      next_q.running = 1'b1;
      next_q.cnt     = tif.reload;
    end else if (q.running && tif.tick) begin
      if (q.cnt == '0) begin
        next_q.tc      = 1'b1;
        next_q.running = 1'b0;
        next_q.fired   = 1'b1;
      end else begin
        next_q.cnt = q.cnt - 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tif.tc    = q.tc;
  assign tif.fired = q.fired;

  //----------------------------------------
  // Checks
  //----------------------------------------
  a_tc_single: assert property (@(posedge hclk) disable iff (!hresetn) q.tc |=> !q.tc && !q.running)
    else $error("terminal count longer than one cycle");
  a_tc_at_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    q.tc |-> $past(q.cnt) == 6'h00 && $past(q.running) && $past(tif.tick))
    else $error("terminal count without reaching zero");
  a_load_start: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tif.start) |=> q.cnt == $past(tif.reload) && q.running)
    else $error("timer did not load its start count");
  c_tc_seen: cover property (@(posedge hclk) disable iff (!hresetn) q.tc);

endmodule : tsc_one_shot

// ---- tb/tsc_front_model.sv ----
// Behavioural model of the analog front end that feeds the counter control
module tsc_front_model (
  input  logic       hclk,
  input  logic       go,
  input  logic [7:0] plen,
  output logic       comparator0,
  output logic       comparator1,
  output logic       slow_internal_osc,
  output logic       internal_timer,
  output logic       analog_bus,
  output logic       relax_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h00;
  logic [3:0] div  = 4'h0;

  // Comparator pulse of plen cycles on request; oscillators free running
  always @(posedge hclk) begin
    if (go) begin
      left <= plen;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
    div <= div + 4'h1;
  end

  // Slow source is kept slow so it never swamps the counter under test
  assign comparator0       = (left != 8'h00);
  assign comparator1       = ~comparator0;
  assign slow_internal_osc = div[3];
  assign internal_timer    = div[2];
  assign relax_osc         = div[1];
  assign analog_bus        = div[0];
endmodule : tsc_front_model

// ---- tb/tb_top.sv ----
// Self-checking testbench of the touch sense counter control
module tb_top
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, unit_irq, ttc, go, refc, cie;
  logic        c0, c1, sio, itm, abus, rosc;
  logic [31:0] haddr, hwdata, hrdata;
  logic        pclk, pxe, roe, cdir, cbus, offs, rsel, rbuf;
  logic [1:0]  htrans, cscale, lpt, lpi;
  logic [2:0]  hsize;
  logic [7:0]  plen, rd, v1;
  int          miscompares = 0, n_tests = 0, cyc = 0, pulses;

  tsc_counter_control tsc_counter_control_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .comparator0(c0), .comparator1(c1), .slow_internal_osc(sio),
    .internal_timer(itm), .analog_bus(abus), .relax_osc(rosc), .unit_irq(unit_irq), .timer_terminal_count(ttc),
    .pin_precharge_clk(pclk), .pin_precharge_clock_enable(pxe), .relax_osc_enable(roe),
    .charge_integration_enable(cie), .current_scale(cscale), .current_direction(cdir), .current_bus_connect(cbus),
    .current_offset_add(offs), .reference_source_select(rsel), .reference_buffer_enable(rbuf), .reference_connect(refc),
    .lowpass_time_constant(lpt), .lowpass_insert_select(lpi));
  tsc_front_model tsc_front_model_inst (.hclk(hclk), .go(go), .plen(plen), .comparator0(c0), .comparator1(c1),
    .slow_internal_osc(sio), .internal_timer(itm), .analog_bus(abus), .relax_osc(rosc));

  //----------------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Single word transfer; hready is sampled at the rising edge, read data taken there too
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask : rdc

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 8; i++) rdc("reset value", 8'ha0 + i[7:0], 8'h00);
    rdc("unmapped", 8'hff, 8'h00);
    bus(1'b1, 8'ha7, 8'hff);
    rdc("timer reload", 8'ha7, 8'h3f);
    bus(1'b1, 8'ha4, 8'h55);
    rdc("low count write", 8'ha4, 8'h00);
    bus(1'b1, 8'ha3, 8'hff);
    repeat (2) @(negedge hclk);
    chk("ref connect on", {7'h0, refc}, 8'h01);
    chk("filter outs", {1'b0, offs, rsel, rbuf, lpt, lpi}, 8'h7f);
    @(posedge hclk);
    bus(1'b1, 8'ha2, 8'hff);
    repeat (2) @(negedge hclk);
    chk("ref connect gated", {7'h0, refc}, 8'h00);
    chk("scale out", {1'b0, cscale, cdir, cbus, pxe, cie, roe}, 8'h7f);
    @(posedge hclk);
    bus(1'b1, 8'ha2, 8'h00);
    $display("register test done");
  endtask : t_regs

  // Cascaded run that stops on the low carry; config written while disabled
  task automatic t_stop();
    bus(1'b1, 8'ha1, 8'h87);
    bus(1'b1, 8'ha6, 8'hf4);
    bus(1'b1, 8'ha0, 8'h01);
    for (int n = 0; n < 600 && unit_irq !== 1'b1; n++) @(posedge hclk);
    rdc("carry flags", 8'ha6, 8'h44);
    rdc("cascade high", 8'ha5, 8'h01);
    rdc("held low", 8'ha4, 8'h00);
    bus(1'b1, 8'ha6, 8'hb4);
    rdc("flag cleared", 8'ha6, 8'h04);
    chk("irq cleared", {7'h0, unit_irq}, 8'h00);
    bus(1'b1, 8'ha0, 8'h00);
    rdc("low zeroed", 8'ha4, 8'h00);
    rdc("high zeroed", 8'ha5, 8'h00);
    $display("stop on event test done");
  endtask : t_stop

  task automatic t_width();
    bus(1'b1, 8'ha1, 8'h00);
    bus(1'b1, 8'ha6, 8'hf1);
    bus(1'b1, 8'ha0, 8'h03);
    plen <= 8'h14;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    for (int n = 0; n < 100 && unit_irq !== 1'b1; n++) @(posedge hclk);
    rdc("width flags", 8'ha6, 8'h91);
    rdc("width count", 8'ha4, 8'h14);
    bus(1'b1, 8'ha0, 8'h00);
    rdc("flags cleared", 8'ha6, 8'h01);
    $display("pulse width test done");
  endtask : t_width

  // Timer on the divided clock, its terminal count used as the event source
  task automatic t_timer();
    bus(1'b1, 8'ha7, 8'h05);
    bus(1'b1, 8'ha2, 8'h04);
    bus(1'b1, 8'ha1, 8'h03);
    bus(1'b1, 8'ha6, 8'hf8);
    bus(1'b1, 8'ha0, 8'h01);
    pulses = 0;
    repeat (60) begin
      @(negedge hclk);
      pulses += int'(ttc === 1'b1);
    end
    v1 = {7'h0, pclk};
    @(negedge hclk);
    chk("pin clock", {7'h0, pclk}, v1 ^ 8'h01);
    @(posedge hclk);
    chk("tc pulses", pulses[7:0], 8'h01);
    chk("edge irq", {7'h0, unit_irq}, 8'h01);
    rdc("edge flag", 8'ha6, 8'h88);
    bus(1'b1, 8'ha0, 8'h00);
    $display("timer test done");
  endtask : t_timer

  // Inverted timer input period on a halved clock, high byte on relax_osc; then continuous cascade
  task automatic t_period();
    bus(1'b1, 8'ha1, 8'h3c);
    bus(1'b1, 8'ha6, 8'hf1);
    bus(1'b1, 8'ha0, 8'h05);
    for (int n = 0; n < 100 && unit_irq !== 1'b1; n++) @(posedge hclk);
    rdc("period flags", 8'ha6, 8'h91);
    rdc("period low", 8'ha4, 8'h04);
    rdc("osc high", 8'ha5, 8'h02);
    bus(1'b1, 8'ha0, 8'h00);
    bus(1'b1, 8'ha1, 8'h8c);
    bus(1'b1, 8'ha6, 8'hf4);
    bus(1'b1, 8'ha0, 8'h07);
    repeat (2) begin
      for (int n = 0; n < 600 && unit_irq !== 1'b1; n++) @(posedge hclk);
      rdc("continuous flags", 8'ha6, 8'hc4);
      bus(1'b1, 8'ha6, 8'hb4);
      @(posedge hclk);
      chk("irq dropped", {7'h0, unit_irq}, 8'h00);
    end
    bus(1'b1, 8'ha0, 8'h00);
    $display("period and continuous test done");
  endtask : t_period

  //----------------------------------------------------------------------------
  // Clock, timeout and main sequence
  //----------------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      $display("Timeout after %0d cycles", cyc);
      final_report();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = TSC_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    go = 1'b0;
    plen = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_stop();
    t_width();
    t_timer();
    t_period();
    final_report();
  end
endmodule : tb_top
